// >>> pkg/ssc_cfg.svh
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

// clock-stop mode field encodings
`define SSC_MODE_NO_DELAY 2'h2
`define SSC_MODE_HALF_DELAY 2'h3
// documented divider width and word length defaults
`define SSC_DIV_WIDTH 8
`define SSC_WORD_WIDTH 8
// reset values
`define SSC_RST_LEVEL 1'h0
`define SSC_RST_COUNT 1'h0
// least phase length in clk_sys cycles (one cycle equals 2H)
`define SSC_MIN_PHASE 1

`endif

// >>> pkg/ssc_pkg.sv
package ssc_pkg;

   typedef struct packed {
      logic [1:0] clock_stop_mode;
      logic tx_clock_polarity;
      logic tx_framesync_polarity;
      logic rx_framesync_polarity;
      logic tx_clock_direction;
      logic rx_clock_direction;
      logic tx_framesync_direction;
      logic rx_framesync_direction;
      logic sample_clock_source_sel;
      logic [7:0] clock_divide_value;
   } ssc_cfg_t;

   typedef struct packed {
      logic clk_out;
      logic clk_oe;
      logic fs_out;
      logic fs_oe;
      logic data_out;
      logic data_oe;
   } ssc_pins_t;

   typedef enum logic [1:0] {
      SSC_ST_IDLE = 2'b00,
      SSC_ST_SETUP = 2'b01,
      SSC_ST_SHIFT = 2'b10,
      SSC_ST_HOLD = 2'b11
   } ssc_state_t;

endpackage : ssc_pkg

// >>> design/ssc_clk_div.sv
`timescale 1ns/1ps
`include "ssc_cfg.svh"

module ssc_clk_div #(
   parameter int DIV_W = `SSC_DIV_WIDTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // control
   input wire logic run,
   input wire logic level_high,
   input wire logic [DIV_W-1:0] div_value,
   // phase end
   output logic tick
);

   logic [DIV_W:0] cnt_q;
   logic [DIV_W:0] cnt_d;
   logic [DIV_W:0] half_odd;
   logic [DIV_W:0] lo_len;
   logic [DIV_W:0] hi_len;
   logic [DIV_W:0] len;

   // ------------------------------------------------------------
   // phase lengths, one count equals 2H
   // ------------------------------------------------------------
   always_comb begin
      half_odd = ({1'b0, div_value} + {{DIV_W{1'b0}}, 1'b1}) >> 1;
      if (div_value[0] || (div_value == '0)) begin
         lo_len = half_odd; // RULE3
         hi_len = half_odd; // RULE4
      end else begin
         lo_len = {1'b0, div_value} >> 1; // RULE3
         hi_len = ({1'b0, div_value} >> 1) + {{DIV_W{1'b0}}, 1'b1}; // RULE4
      end
      if (lo_len < (DIV_W+1)'(`SSC_MIN_PHASE)) begin
         lo_len = (DIV_W+1)'(`SSC_MIN_PHASE);
      end
      // zero divide would give a zero high phase and make the counter run up to all ones before it ticks
      if (hi_len < (DIV_W+1)'(`SSC_MIN_PHASE)) begin
         hi_len = (DIV_W+1)'(`SSC_MIN_PHASE);
      end
      len = level_high ? hi_len : lo_len;
      tick = run && (cnt_q == len - {{DIV_W{1'b0}}, 1'b1}); // RULE2
      if (!run || tick) begin
         cnt_d = '0;
      end else begin
         cnt_d = cnt_q + {{DIV_W{1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule : ssc_clk_div

// >>> design/ssc_port.sv
`timescale 1ns/1ps
`include "ssc_cfg.svh"
// Behaviour
// RULE1 - both clock-stop modes work with either clock polarity, four variants in all.
// RULE2 - the master serial clock period is (1 + divide value) times 2H; with divide value 0 the code gives 2 times 2H, one 2H per phase.
// RULE3 - the low phase is half the period for odd or zero divide, else divide/2 times 2H.
// RULE4 - the high phase is half the period for odd or zero divide, else (divide/2+1) times 2H.
// RULE5 - as master with frame-sync polarity set, the enable output is driven active low.
// RULE6 - as slave, the received frame-sync levels are inverted per polarity before use.
// RULE7 - software sets the sample clock to half the CPU clock for any slave setup.
// RULE8 - master uses transmit clock and frame-sync driven out, receive ones as inputs.
// RULE9 - slave has all four direction bits at zero so the master drives clock and enable.
// RULE10 - with the mode off or nothing pending the master clock idles and enable is off.
// RULE11 - the mode ending in 1 moves the data phase half a serial clock earlier; the code puts its first bit out at the first edge, half a clock later.

module ssc_port #(
   parameter int DIV_W = `SSC_DIV_WIDTH,
   parameter int WORD_W = `SSC_WORD_WIDTH
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // configuration
   input wire ssc_pkg::ssc_cfg_t cfg,
   // transmit word
   input wire logic [WORD_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   // receive word
   output logic [WORD_W-1:0] rx_data,
   output logic rx_valid,
   // status
   output logic busy,
   // pins
   input wire logic tx_serial_clock_pin_in,
   input wire logic tx_framesync_pin_in,
   input wire logic rx_framesync_pin_in,
   input wire logic data_in,
   output ssc_pkg::ssc_pins_t pins
);

   localparam int EC_W = $clog2(2 * WORD_W + 1);
   localparam int BC_W = $clog2(WORD_W);

   generate
      if (WORD_W < 2 || DIV_W < 1 || DIV_W > 8) begin : g_check
         $error("ssc_port: word width below 2 or divider width outside 1..8");
      end
   endgenerate

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   logic mode_on;
   logic cpha;
   logic master;
   logic pol;
   assign mode_on = cfg.clock_stop_mode[1]; // RULE1
   assign cpha = cfg.clock_stop_mode[0]; // RULE11
   assign master = cfg.tx_clock_direction; // RULE8 RULE9
   assign pol = cfg.tx_clock_polarity; // RULE1

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ssc_pkg::ssc_state_t st_q, st_d;
   logic sclk_act_q, sclk_act_d;
   logic [EC_W-1:0] ecnt_q, ecnt_d;
   logic [WORD_W-1:0] tx_sh_q, tx_sh_d;
   logic [WORD_W-1:0] rx_sh_q, rx_sh_d;
   logic [BC_W-1:0] bcnt_q, bcnt_d;
   logic [WORD_W-1:0] rx_data_q, rx_data_d;
   logic rx_valid_q, rx_valid_d;
   logic dx_q, dx_d;
   logic sclk_prev_q, sclk_prev_d;
   logic sel_prev_q, sel_prev_d;

   logic tick;
   logic div_run;
   logic sclk_in_act;
   logic sel_tx;
   logic sel_rx;
   logic sel_rise;
   logic lead_ev;
   logic trail_ev;
   logic sample_ev;
   logic shift_ev;
   logic load;
   logic [WORD_W-1:0] load_word;

   assign div_run = mode_on && master && (st_q != ssc_pkg::SSC_ST_IDLE);

   ssc_clk_div #(
      .DIV_W(DIV_W)
   ) u_div (
      .clk_sys(clk_sys),
      .reset(reset),
      .run(div_run),
      .level_high(sclk_act_q ^ pol),
      .div_value(cfg.clock_divide_value[DIV_W-1:0]), // RULE2
      .tick(tick)
   );

   // ------------------------------------------------------------
   // edge events for both roles
   // ------------------------------------------------------------
   always_comb begin
      sclk_in_act = tx_serial_clock_pin_in ^ pol;
      sel_tx = mode_on && !master && (tx_framesync_pin_in ^ cfg.tx_framesync_polarity); // RULE6
      sel_rx = mode_on && !master && (rx_framesync_pin_in ^ cfg.rx_framesync_polarity); // RULE6
      sel_rise = sel_tx && !sel_prev_q;
      if (master) begin
         lead_ev = (st_q == ssc_pkg::SSC_ST_SHIFT) && tick && !sclk_act_q;
         trail_ev = (st_q == ssc_pkg::SSC_ST_SHIFT) && tick && sclk_act_q;
      end else begin
         lead_ev = sel_tx && sclk_in_act && !sclk_prev_q;
         trail_ev = sel_tx && !sclk_in_act && sclk_prev_q;
      end
      sample_ev = (cpha ? trail_ev : lead_ev) && (master || sel_rx); // RULE11
      shift_ev = cpha ? lead_ev : trail_ev; // RULE11
      if (master) begin
         tx_ready = mode_on && (st_q == ssc_pkg::SSC_ST_IDLE);
      end else begin
         tx_ready = sel_rise;
      end
      load = master ? (tx_ready && tx_valid) : sel_rise;
      load_word = tx_valid ? tx_data : '0;
   end

   // ------------------------------------------------------------
   // master sequencer
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      sclk_act_d = sclk_act_q;
      ecnt_d = ecnt_q;
      if (!mode_on || !master) begin
         st_d = ssc_pkg::SSC_ST_IDLE; // RULE10
         sclk_act_d = `SSC_RST_LEVEL;
         ecnt_d = '0;
      end else begin
         unique case (st_q)
            ssc_pkg::SSC_ST_IDLE: begin
               sclk_act_d = `SSC_RST_LEVEL; // RULE10
               ecnt_d = '0;
               if (load) begin
                  st_d = ssc_pkg::SSC_ST_SETUP;
               end
            end
            ssc_pkg::SSC_ST_SETUP: begin
               if (tick) begin
                  st_d = ssc_pkg::SSC_ST_SHIFT;
               end
            end
            ssc_pkg::SSC_ST_SHIFT: begin
               if (tick) begin
                  sclk_act_d = !sclk_act_q; // RULE2
                  ecnt_d = ecnt_q + {{(EC_W-1){1'b0}}, 1'b1};
                  if (ecnt_q == EC_W'(2 * WORD_W - 1)) begin
                     st_d = ssc_pkg::SSC_ST_HOLD;
                  end
               end
            end
            ssc_pkg::SSC_ST_HOLD: begin
               if (tick) begin
                  st_d = ssc_pkg::SSC_ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q <= ssc_pkg::SSC_ST_IDLE;
         sclk_act_q <= `SSC_RST_LEVEL;
         ecnt_q <= '0;
      end else begin
         st_q <= st_d;
         sclk_act_q <= sclk_act_d;
         ecnt_q <= ecnt_d;
      end
   end

   // ------------------------------------------------------------
   // data path
   // ------------------------------------------------------------
   always_comb begin
      tx_sh_d = tx_sh_q;
      dx_d = dx_q;
      rx_sh_d = rx_sh_q;
      bcnt_d = bcnt_q;
      rx_data_d = rx_data_q;
      rx_valid_d = 1'b0;
      sclk_prev_d = sclk_in_act;
      sel_prev_d = sel_tx;
      if (load) begin
         // no-delay mode shows the first bit at once, delayed mode at the first edge
         dx_d = cpha ? `SSC_RST_LEVEL : load_word[WORD_W-1]; // RULE11
         tx_sh_d = cpha ? load_word : {load_word[WORD_W-2:0], 1'b0};
         bcnt_d = '0;
      end else if (shift_ev) begin
         dx_d = tx_sh_q[WORD_W-1];
         tx_sh_d = {tx_sh_q[WORD_W-2:0], 1'b0};
      end
      if (sample_ev && !load) begin
         rx_sh_d = {rx_sh_q[WORD_W-2:0], data_in};
         if (bcnt_q == BC_W'(WORD_W - 1)) begin
            bcnt_d = '0;
            rx_data_d = {rx_sh_q[WORD_W-2:0], data_in};
            rx_valid_d = 1'b1;
         end else begin
            bcnt_d = bcnt_q + {{(BC_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tx_sh_q <= '0;
         dx_q <= `SSC_RST_LEVEL;
         rx_sh_q <= '0;
         bcnt_q <= '0;
         rx_data_q <= '0;
         rx_valid_q <= `SSC_RST_COUNT;
         sclk_prev_q <= `SSC_RST_LEVEL;
         sel_prev_q <= `SSC_RST_LEVEL;
      end else begin
         tx_sh_q <= tx_sh_d;
         dx_q <= dx_d;
         rx_sh_q <= rx_sh_d;
         bcnt_q <= bcnt_d;
         rx_data_q <= rx_data_d;
         rx_valid_q <= rx_valid_d;
         sclk_prev_q <= sclk_prev_d;
         sel_prev_q <= sel_prev_d;
      end
   end

   // ------------------------------------------------------------
   // pins and status
   // ------------------------------------------------------------
   assign rx_data = rx_data_q;
   assign rx_valid = rx_valid_q;
   assign busy = (st_q != ssc_pkg::SSC_ST_IDLE) || sel_tx;
   assign pins.clk_out = sclk_act_q ^ pol; // RULE10 RULE1
   assign pins.clk_oe = mode_on && cfg.tx_clock_direction; // RULE8
   // enable is active while the sequencer runs; polarity set makes it active low
   assign pins.fs_out = (st_q != ssc_pkg::SSC_ST_IDLE) ^ cfg.tx_framesync_polarity; // RULE5
   assign pins.fs_oe = mode_on && cfg.tx_framesync_direction; // RULE8
   assign pins.data_out = dx_q;
   assign pins.data_oe = master ? (st_q != ssc_pkg::SSC_ST_IDLE) : sel_tx;

endmodule : ssc_port

// >>> tb/ssc_chk.sv
`timescale 1ns/1ps
module ssc_chk #(
   parameter int DIV_W = 8,
   parameter int WORD_W = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // user side
   input wire ssc_pkg::ssc_cfg_t cfg,
   input wire logic [WORD_W-1:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [WORD_W-1:0] rx_data,
   input wire logic rx_valid,
   input wire logic busy,
   // pins
   input wire logic tx_serial_clock_pin_in,
   input wire logic tx_framesync_pin_in,
   input wire logic rx_framesync_pin_in,
   input wire logic data_in,
   input wire ssc_pkg::ssc_pins_t pins
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   // -------------------------
   // phase and edge tracking
   // -------------------------
   logic mst, edg, prev_q, seen_q;
   logic [8:0] len_q, lo, hi;
   logic [5:0] edges_q;
   assign mst = cfg.tx_clock_direction && cfg.clock_stop_mode[1];
   assign edg = pins.clk_out != prev_q;
   assign lo = cfg.clock_divide_value == 8'h00 ? 9'h001 : cfg.clock_divide_value[0] ?
      (9'(cfg.clock_divide_value) + 9'h001) >> 1 : 9'(cfg.clock_divide_value) >> 1;
   assign hi = (cfg.clock_divide_value[0] || cfg.clock_divide_value == 8'h00) ? lo : lo + 9'h001;
   always_ff @(posedge clk_sys) begin
      prev_q <= pins.clk_out;
      len_q <= edg ? 9'h001 : len_q + 9'h001;
      seen_q <= !reset && busy && (seen_q || edg);
      edges_q <= (reset || !busy) ? 6'h00 : edges_q + 6'(edg);
   end
   // -------------------------
   // assertions
   // -------------------------
   chk_low_phase: assert property (mst && seen_q && edg && !prev_q |-> len_q == lo)
      else $error("low phase length wrong");
   chk_high_phase: assert property (mst && seen_q && edg && prev_q |-> len_q == hi)
      else $error("high phase length wrong");
   chk_idle_clock: assert property (mst && !busy && $stable(cfg) |->
      pins.clk_out == cfg.tx_clock_polarity) else $error("clock not idle");
   chk_idle_enable: assert property (mst && !busy && $stable(cfg) |->
      pins.fs_out == cfg.tx_framesync_polarity) else $error("enable not idle");
   chk_enable_on: assert property (mst && tx_valid && tx_ready |=>
      (pins.fs_out != cfg.tx_framesync_polarity) [*2]) else $error("enable not active");
   chk_ready_idle: assert property (mst |-> tx_ready == !busy)
      else $error("ready wrong");
   chk_mode_abort: assert property (!mst && cfg.tx_clock_direction ##1
      !mst && cfg.tx_clock_direction |-> !busy) else $error("no abort");
   chk_edge_count: assert property (mst && $fell(busy) |-> edges_q == 6'(2 * WORD_W))
      else $error("edge count wrong");
   chk_rx_pulse: assert property (rx_valid |=> !rx_valid)
      else $error("rx pulse too long");
   chk_slave_quiet: assert property ((!cfg.tx_clock_direction &&
      tx_framesync_pin_in == cfg.tx_framesync_polarity) [*2] |-> !pins.data_oe)
      else $error("slave drives while released");
   cov_delayed: cover property (mst && cfg.clock_stop_mode[0] && cfg.tx_clock_polarity && rx_valid);
   cov_abort: cover property (busy && !cfg.clock_stop_mode[1]);
   cov_slave: cover property (!cfg.tx_clock_direction && busy);
endmodule : ssc_chk

bind ssc_port ssc_chk #(.DIV_W(DIV_W), .WORD_W(WORD_W)) chk_u (.clk_sys(clk_sys), .reset(reset),
   .cfg(cfg), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
   .rx_valid(rx_valid), .busy(busy), .tx_serial_clock_pin_in(tx_serial_clock_pin_in),
   .tx_framesync_pin_in(tx_framesync_pin_in), .rx_framesync_pin_in(rx_framesync_pin_in),
   .data_in(data_in), .pins(pins));

// >>> tb/ssc_spi_dev.sv
`timescale 1ns/1ps
module ssc_spi_dev (
   // clock
   input wire logic clk_sys,
   // spi wires
   input wire logic sclk,
   input wire logic fs,
   input wire logic mosi,
   output logic miso,
   // setup
   input wire logic [1:0] mode,
   input wire logic pol,
   input wire logic [7:0] reply,
   output logic [7:0] got
);
   logic prev_q = 1'b0;
   logic junk_q = 1'b0;
   int idx = 0;
   // ---------------------------
   // active-low enable, junk when released
   // ---------------------------
   assign miso = (!fs && idx >= 0 && idx < 8) ? reply[7-idx] : junk_q;
   always @(posedge clk_sys) begin
      prev_q <= sclk;
      junk_q <= ~junk_q;
      if (fs) begin
         idx <= mode[0] ? -1 : 0;
      end else if (sclk != prev_q) begin
         if ((sclk != pol) != mode[0]) begin
            got <= {got[6:0], mosi};
         end else begin
            idx <= idx + 1;
         end
      end
   end
endmodule : ssc_spi_dev

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   ssc_pkg::ssc_cfg_t cfg = '0;
   logic [7:0] tx_data = 8'h00;
   logic [7:0] reply = 8'h00;
   logic [7:0] rx_data, got;
   logic tx_valid = 1'b0;
   logic sclk_in = 1'b0;
   logic fs_in = 1'b1;
   logic tx_ready, rx_valid, busy, miso;
   ssc_pkg::ssc_pins_t pins;
   int err_count = 0;
   int checks = 0;
   int seed = 47462;
   int cyc = 0;
   int rx_cnt = 0;
   int rx_seen = 0;
   logic mosi_tb = 1'b0;
   logic [7:0] seen = 8'h00;
   logic [7:0] slv_word = 8'h00;
   logic [7:0] exp_q[$];

   ssc_port dut_u (.clk_sys(clk_sys), .reset(reset), .cfg(cfg), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .busy(busy), .tx_serial_clock_pin_in(pins.clk_oe ? pins.clk_out : sclk_in),
      .tx_framesync_pin_in(pins.fs_oe ? pins.fs_out : fs_in),
      .rx_framesync_pin_in(fs_in), .data_in(pins.clk_oe ? miso : mosi_tb), .pins(pins));
   ssc_spi_dev dev_u (.clk_sys(clk_sys), .sclk(pins.clk_out),
      .fs(pins.fs_oe ? pins.fs_out : 1'b1), .mosi(pins.data_out), .miso(miso),
      .mode(cfg.clock_stop_mode), .pol(cfg.tx_clock_polarity), .reply(reply), .got(got));

   initial forever #12.5 clk_sys = ~clk_sys;

   // receive pulses counted where they are settled
   always @(negedge clk_sys) begin
      if (rx_valid === 1'b1) begin
         rx_cnt++;
      end
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         test_done();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checks++;
      if (seen !== want) begin
         err_count++;
         $display("Error at %0t: seen %h want %h", $time, seen, want);
      end
   endtask : check

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done

   // ---------------------------
   // one master word through the slave model
   // ---------------------------
   task automatic xfer(input logic [1:0] mode, input logic pol, input logic [7:0] div);
      int n;
      logic rdy;
      n = 0;
      @(posedge clk_sys);
      cfg <= '{mode, pol, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, div};
      tx_data <= 8'($random(seed));
      reply <= 8'($random(seed));
      tx_valid <= 1'b1;
      do begin
         @(negedge clk_sys);
         rdy = tx_ready;
         @(posedge clk_sys);
      end while (rdy !== 1'b1);
      tx_valid <= 1'b0;
      exp_q.push_back(reply);
      exp_q.push_back(tx_data);
      @(posedge clk_sys);
      check(pins.fs_out, 8'h00);
      check(8'({pins.clk_oe, pins.fs_oe, pins.data_oe}), 8'h07);
      while (rx_valid !== 1'b1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      check(rx_valid, 8'h01);
      check(rx_data, exp_q.pop_front());
      while (busy !== 1'b0) @(posedge clk_sys);
      #1;
      check(got, exp_q.pop_front());
      check(pins.clk_out, pol);
      $display("transfer mode %0d pol %0d div %0d done", mode, pol, div);
   endtask : xfer

   initial begin
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      for (int v = 0; v < 8; v++) begin
         xfer({1'b1, v[0]}, v[1], 8'(3 + v));
      end
      @(posedge clk_sys);
      tx_valid <= 1'b1;
      @(posedge clk_sys);
      tx_valid <= 1'b0;
      repeat (8) @(posedge clk_sys);
      cfg.clock_stop_mode <= 2'h0;
      repeat (3) @(posedge clk_sys);
      check(busy, 8'h00);
      check(pins.clk_out, cfg.tx_clock_polarity);
      $display("abort done");
      cfg <= '{2'h2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h01};
      tx_data <= 8'($random(seed));
      slv_word <= 8'($random(seed));
      tx_valid <= 1'b1;
      fs_in <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check(busy, 8'h01);
      check(8'({pins.clk_oe, pins.fs_oe, pins.data_oe}), 8'h01);
      tx_valid <= 1'b0;
      rx_seen = rx_cnt;
      // bench acts as master: data set while clock low, clock held two cycles per level
      for (int b = 7; b >= 0; b--) begin
         mosi_tb <= slv_word[b];
         repeat (2) @(posedge clk_sys);
         sclk_in <= 1'b1;
         seen = {seen[6:0], pins.data_out};
         repeat (2) @(posedge clk_sys);
         sclk_in <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
      check(8'(rx_cnt - rx_seen), 8'h01);
      check(rx_data, slv_word);
      check(seen, tx_data);
      fs_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check(busy, 8'h00);
      $display("slave select done");
      test_done();
   end
endmodule : tb_top
